// [rtl/pei_defines.svh]
// Register offsets, field positions and reset values of the PCIe error interrupt block
`ifndef PEI_DEFINES_SVH
`define PEI_DEFINES_SVH

`define PEI_CAUSE_OFFSET     16'h5b88
`define PEI_MASK_OFFSET      16'h5b8c
`define PEI_CTRL_OFFSET      16'h5b90
`define PEI_ADDR_W           16

`define PEI_BIT_COMPL_ABORT  0
`define PEI_BIT_UNUSED       1
`define PEI_BIT_BYTE_EN      2
`define PEI_BIT_TIMEOUT      3
`define PEI_BIT_BM_DROP      4
`define PEI_BIT_ABORT_RCVD   5
`define PEI_NUM_CAUSES       6

`define PEI_IMPL_MASK        6'h3d
`define PEI_CAUSE_RESET      6'h00
`define PEI_MASK_RESET       6'h00
`define PEI_CTRL_SOFT_RST    0

`endif

// [rtl/pei_event_sync.sv]
// Two-flop synchroniser with rising-edge detect for one event line
`timescale 1ns/1ns
module pei_event_sync (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Event
  input  wire logic i_level,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= i_level;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise  = sync_q & ~last_q;
  assign o_fall  = ~sync_q & last_q;

endmodule

// [rtl/pei_pkg.sv]
// Types shared by the PCIe error interrupt block
package pei_pkg;

  typedef logic [5:0] pei_cause_t;

  // Exception events from the host interface, one-cycle pulses or levels
  typedef struct packed {
    logic abort_received;
    logic bus_master_allow;
    logic timeout;
    logic byte_enable_err;
    logic completion_abort;
  } pei_events_t;

  // APB request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } pei_apb_req_t;

  typedef enum logic [1:0] {
    PEI_IDLE   = 2'b00,
    PEI_ACCESS = 2'b01,
    PEI_DONE   = 2'b11
  } pei_apb_state_t;

endpackage

// [rtl/pei_regs.sv]
// PCIe error cause and mask registers with interrupt and master-halt logic
`timescale 1ns/1ns
`include "pei_defines.svh"

module pei_regs
  import pei_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [15:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Host interface exception events (asynchronous levels)
  input  wire logic        i_completion_abort,
  input  wire logic        i_byte_enable_err,
  input  wire logic        i_timeout,
  input  wire logic        i_bus_master_allow,
  input  wire logic        i_abort_received,
  // Interrupt and master control
  output logic             o_irq,
  output logic             o_master_halt,
  output logic             o_global_soft_reset
);

  // ----------------------------------------------------------------
  // Event synchronisation
  // ----------------------------------------------------------------
  pei_events_t ev_raw;
  pei_events_t ev_rise;
  pei_events_t ev_fall;
  pei_events_t ev_lvl;

  assign ev_raw = '{abort_received:   i_abort_received,
                    bus_master_allow: i_bus_master_allow,
                    timeout:          i_timeout,
                    byte_enable_err:  i_byte_enable_err,
                    completion_abort: i_completion_abort};

  // Completion abort issued
  pei_event_sync u_sync_compl (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_level  (ev_raw.completion_abort),
    .o_level  (ev_lvl.completion_abort),
    .o_rise   (ev_rise.completion_abort),
    .o_fall   (ev_fall.completion_abort)
  );

  // Byte-enable error
  pei_event_sync u_sync_byte_en (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_level  (ev_raw.byte_enable_err),
    .o_level  (ev_lvl.byte_enable_err),
    .o_rise   (ev_rise.byte_enable_err),
    .o_fall   (ev_fall.byte_enable_err)
  );

  // Transaction timeout
  pei_event_sync u_sync_timeout (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_level  (ev_raw.timeout),
    .o_level  (ev_lvl.timeout),
    .o_rise   (ev_rise.timeout),
    .o_fall   (ev_fall.timeout)
  );

  // Bus master allow idles high, its drop is the event
  pei_event_sync u_sync_bm_allow (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_level  (ev_raw.bus_master_allow),
    .o_level  (ev_lvl.bus_master_allow),
    .o_rise   (ev_rise.bus_master_allow),
    .o_fall   (ev_fall.bus_master_allow)
  );

  // Completer abort received
  pei_event_sync u_sync_abort (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_level  (ev_raw.abort_received),
    .o_level  (ev_lvl.abort_received),
    .o_rise   (ev_rise.abort_received),
    .o_fall   (ev_fall.abort_received)
  );

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] offs);
    addr_hit = (addr[15:2] == offs[15:2]);
  endfunction

  function automatic pei_cause_t lane0_data(input logic [31:0] wdata, input logic [3:0] strb);
    lane0_data = strb[0] ? wdata[5:0] : 6'h00;
  endfunction

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  pei_apb_req_t   req;
  pei_apb_state_t state_q;
  pei_apb_state_t state_d;
  logic           wr_fire;
  logic           rd_fire;
  logic           hit_cause;
  logic           hit_mask;
  logic           hit_ctrl;
  logic           hit_any;
  pei_cause_t     wr_bits;

  assign req       = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                       paddr: i_paddr, pwdata: i_pwdata};
  assign hit_cause = addr_hit(req.paddr, `PEI_CAUSE_OFFSET);
  assign hit_mask  = addr_hit(req.paddr, `PEI_MASK_OFFSET);
  assign hit_ctrl  = addr_hit(req.paddr, `PEI_CTRL_OFFSET);
  assign hit_any   = hit_cause | hit_mask | hit_ctrl;
  assign wr_bits   = lane0_data(req.pwdata, i_pstrb) & `PEI_IMPL_MASK;

  // Access completes two cycles after the setup phase, after one wait state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PEI_IDLE:   if (req.psel && !req.penable) state_d = PEI_ACCESS;
      PEI_ACCESS: state_d = PEI_DONE;
      PEI_DONE:   state_d = (req.psel && !req.penable) ? PEI_ACCESS : PEI_IDLE;
      default:    state_d = PEI_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= PEI_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= (state_d == PEI_DONE);
    end
  end

  assign wr_fire = req.psel & req.penable & o_pready & req.pwrite;
  assign rd_fire = req.psel & req.penable & o_pready & ~req.pwrite;

  // ----------------------------------------------------------------
  // Soft reset control
  // ----------------------------------------------------------------
  logic soft_rst_q;

  // Self-clearing pulse written by software
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_fire & hit_ctrl & i_pstrb[0] & req.pwdata[`PEI_CTRL_SOFT_RST];
    end
  end

  assign o_global_soft_reset = soft_rst_q;

  // ----------------------------------------------------------------
  // Cause register
  // ----------------------------------------------------------------
  pei_cause_t cause_q;
  pei_cause_t cause_d;
  pei_cause_t set_bits;
  pei_cause_t clr_bits;
  logic       compl_abort_q;
  logic       byte_en_q;
  logic       timeout_q;
  logic       bm_drop_q;
  logic       abort_rcvd_q;

  localparam pei_cause_t CAUSE_RESET = `PEI_CAUSE_RESET;

  always_comb begin
    set_bits = 6'h00;
    set_bits[`PEI_BIT_COMPL_ABORT] = ev_rise.completion_abort;
    set_bits[`PEI_BIT_BYTE_EN]    = ev_rise.byte_enable_err;
    set_bits[`PEI_BIT_TIMEOUT]    = ev_rise.timeout;
    set_bits[`PEI_BIT_BM_DROP]    = ev_fall.bus_master_allow;
    set_bits[`PEI_BIT_ABORT_RCVD] = ev_rise.abort_received;
  end

  always_comb begin
    clr_bits = (wr_fire && hit_cause) ? wr_bits : 6'h00;
    // Soft reset clears the received-abort halt
    if (soft_rst_q) begin
      clr_bits[`PEI_BIT_ABORT_RCVD] = 1'b1;
    end
    // Set wins over a clear in the same cycle
    cause_d = ((cause_q & ~clr_bits) | set_bits) & `PEI_IMPL_MASK;
  end

  // One flop per cause bit
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      compl_abort_q <= CAUSE_RESET[`PEI_BIT_COMPL_ABORT];
    end else begin
      compl_abort_q <= cause_d[`PEI_BIT_COMPL_ABORT];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      byte_en_q <= CAUSE_RESET[`PEI_BIT_BYTE_EN];
    end else begin
      byte_en_q <= cause_d[`PEI_BIT_BYTE_EN];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      timeout_q <= CAUSE_RESET[`PEI_BIT_TIMEOUT];
    end else begin
      timeout_q <= cause_d[`PEI_BIT_TIMEOUT];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bm_drop_q <= CAUSE_RESET[`PEI_BIT_BM_DROP];
    end else begin
      bm_drop_q <= cause_d[`PEI_BIT_BM_DROP];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      abort_rcvd_q <= CAUSE_RESET[`PEI_BIT_ABORT_RCVD];
    end else begin
      abort_rcvd_q <= cause_d[`PEI_BIT_ABORT_RCVD];
    end
  end

  // Reserved slot one has no flop and reads zero
  always_comb begin
    cause_q                        = 6'h00;
    cause_q[`PEI_BIT_COMPL_ABORT]  = compl_abort_q;
    cause_q[`PEI_BIT_BYTE_EN]      = byte_en_q;
    cause_q[`PEI_BIT_TIMEOUT]      = timeout_q;
    cause_q[`PEI_BIT_BM_DROP]      = bm_drop_q;
    cause_q[`PEI_BIT_ABORT_RCVD]   = abort_rcvd_q;
  end

  // ----------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------
  pei_cause_t mask_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mask_q <= `PEI_MASK_RESET;
    end else if (wr_fire && hit_mask && i_pstrb[0]) begin
      mask_q <= wr_bits;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and master halt
  // ----------------------------------------------------------------
  pei_cause_t pending;

  // Per-bit gating of each cause by its mask bit
  assign pending = cause_d & mask_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |pending;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_master_halt <= 1'b0;
    end else begin
      o_master_halt <= cause_d[`PEI_BIT_ABORT_RCVD];
    end
  end

  // ----------------------------------------------------------------
  // Read data and error
  // ----------------------------------------------------------------
  // Unmapped offsets answer with an error
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= (state_d == PEI_DONE) & ~hit_any;
    end
  end

  // Read data stands only while ready is high
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata <= 32'h0000_0000;
    end else if (state_d != PEI_DONE || req.pwrite) begin
      o_prdata <= 32'h0000_0000;
    end else if (hit_cause) begin
      o_prdata <= {26'h000_0000, cause_q};
    end else if (hit_mask) begin
      o_prdata <= {26'h000_0000, mask_q};
    end else begin
      o_prdata <= 32'h0000_0000;
    end
  end

  logic unused_ok;
  assign unused_ok = rd_fire | (|ev_lvl) | (|ev_fall) | ev_rise.bus_master_allow;

endmodule

// [tb/pei_link_model.sv]
// Link-side event source driving the exception pins
`timescale 1ns/1ns
module pei_link_model
  import pei_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Event request from the bench
  input  wire logic [4:0] i_fire,
  output pei_events_t     o_ev
);
  logic [4:0] act_q;
  logic [2:0] cnt_q;
  // Pin held six cycles so the synchroniser sees it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      act_q <= 5'h00;
      cnt_q <= 3'h0;
    end else if (|i_fire) begin
      act_q <= i_fire;
      cnt_q <= 3'h5;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end else begin
      act_q <= 5'h00;
    end
  end
  // Allow idles high, its event is a drop
  assign o_ev = act_q ^ 5'h08;
endmodule

// [tb/pei_regs_asserts.sv]
// Port checker for the PCIe error interrupt registers
`timescale 1ns/1ns
module pei_regs_asserts (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_abort_received,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_irq,
  input wire logic        o_master_halt,
  input wire logic        o_global_soft_reset
);
  logic [3:0] hist_q;
  // Recent accesses or soft reset pulses
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) hist_q <= 4'h0;
    else hist_q <= {hist_q[2:0], (i_psel & i_penable & o_pready) | o_global_soft_reset};
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_abort_edge;
    $rose(i_abort_received);
  endsequence
  sequence s_halt_soon;
    ##[1:6] o_master_halt;
  endsequence
  a_halt_on_abort: assert property (s_abort_edge |-> s_halt_soon)
    else $error("halt missing after abort");
  a_halt_holds: assert property ($fell(o_master_halt) |-> |hist_q)
    else $error("halt dropped without software");
  a_irq_holds: assert property ($fell(o_irq) |-> |hist_q)
    else $error("irq dropped without software");
  a_reserved_zero: assert property (o_pready |-> (o_prdata[31:6] == 26'h0 && !o_prdata[1]))
    else $error("reserved bits read nonzero");
  a_ready_after_setup: assert property ((i_psel && !i_penable) |-> ##2 o_pready)
    else $error("no ready in access phase");
  a_ready_single: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside ready");
  a_reset_after_write: assert property ($rose(o_global_soft_reset) |-> hist_q[0])
    else $error("soft reset without access");
endmodule
bind pei_regs pei_regs_asserts i_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
  .i_penable(i_penable), .i_abort_received(i_abort_received), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_irq(o_irq), .o_master_halt(o_master_halt), .o_global_soft_reset(o_global_soft_reset));

// [tb/test_pei_regs.sv]
// Self-checking bench for the PCIe error interrupt registers
`timescale 1ns/1ns
`include "pei_defines.svh"
module test_pei_regs
  import pei_pkg::*;
;
  typedef struct packed {logic [4:0] fire; logic [5:0] mask; logic [5:0] cause; logic irq;} pei_row_t;
  localparam pei_row_t ROWS [6] = '{
    '{5'h01, 6'h3d, 6'h01, 1'b1},
    '{5'h02, 6'h04, 6'h04, 1'b1},
    '{5'h04, 6'h08, 6'h08, 1'b1},
    '{5'h08, 6'h10, 6'h10, 1'b1},
    '{5'h10, 6'h20, 6'h20, 1'b1},
    '{5'h01, 6'h3c, 6'h01, 1'b0}};
  logic        i_clk, i_resetn, psel, penable, pwrite, err;
  logic        pready, pslverr, irq, halt, sreset;
  logic [15:0] paddr;
  logic [31:0] pwdata, rd, prdata;
  logic [4:0]  fire;
  pei_events_t ev;
  int          num_errors, compares;
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  pei_link_model i_link (.i_clk(i_clk), .i_resetn(i_resetn), .i_fire(fire), .o_ev(ev));
  pei_regs i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_completion_abort(ev.completion_abort),
    .i_byte_enable_err(ev.byte_enable_err), .i_timeout(ev.timeout),
    .i_bus_master_allow(ev.bus_master_allow), .i_abort_received(ev.abort_received),
    .o_irq(irq), .o_master_halt(halt), .o_global_soft_reset(sreset));
  task automatic tally_and_finish();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
    if (n >= 20) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task automatic raise(input logic [4:0] f);
    fire <= f;
    @(posedge i_clk);
    fire <= 5'h00;
    repeat (12) @(posedge i_clk);
  endtask
  initial begin
    {i_resetn, psel, penable, pwrite, paddr, pwdata, fire} = '0;
    num_errors = 0;
    compares = 0;
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    apb(0, `PEI_CAUSE_OFFSET, 0);
    chk("cause", 0, rd);
    apb(0, `PEI_MASK_OFFSET, 0);
    chk("mask", 0, rd);
    apb(1, `PEI_MASK_OFFSET, 32'hffffffff);
    apb(0, `PEI_MASK_OFFSET, 0);
    chk("mask", 32'h3d, rd);
    apb(0, 16'h5b80, 0);
    chk("slverr", 1, err);
    $display("test reset done");
    for (int r = 0; r < 6; r++) begin
      apb(1, `PEI_MASK_OFFSET, ROWS[r].mask);
      raise(ROWS[r].fire);
      apb(0, `PEI_CAUSE_OFFSET, 0);
      chk("cause", ROWS[r].cause, rd);
      chk("irq", ROWS[r].irq, irq);
      chk("halt", ROWS[r].fire[4], halt);
      apb(1, `PEI_CAUSE_OFFSET, ROWS[r].cause);
      repeat (2) @(posedge i_clk);
      chk("irq", 0, irq);
    end
    $display("test rows done");
    apb(1, `PEI_MASK_OFFSET, 32'h3d);
    raise(5'h03);
    apb(1, `PEI_CAUSE_OFFSET, 32'h1);
    apb(0, `PEI_CAUSE_OFFSET, 0);
    chk("cause", 32'h4, rd);
    chk("irq", 1, irq);
    apb(1, `PEI_MASK_OFFSET, 0);
    repeat (2) @(posedge i_clk);
    chk("irq", 0, irq);
    $display("test partial clear done");
    raise(5'h10);
    apb(1, `PEI_CAUSE_OFFSET, 0);
    chk("halt", 1, halt);
    apb(1, `PEI_CTRL_OFFSET, 32'h1);
    chk("sreset", 1, sreset);
    repeat (4) @(posedge i_clk);
    chk("halt", 0, halt);
    chk("sreset", 0, sreset);
    apb(0, `PEI_CAUSE_OFFSET, 0);
    chk("cause", 32'h4, rd);
    $display("test soft reset done");
    apb(1, `PEI_MASK_OFFSET, 32'h3d);
    raise(5'h11);
    chk("irq", 1, irq);
    chk("halt", 1, halt);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("irq", 0, irq);
    chk("halt", 0, halt);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    apb(0, `PEI_CAUSE_OFFSET, 0);
    chk("cause", 0, rd);
    apb(0, `PEI_MASK_OFFSET, 0);
    chk("mask", 0, rd);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule
